// ==== hlrb_defines.svh ====
`ifndef HLRB_DEFINES_SVH
`define HLRB_DEFINES_SVH
// Settle counts, in byte-rate enable ticks
`define HLRB_SOFT_DSETTLE_MIN  5'd1
`define HLRB_SOFT_DSETTLE_MAX  5'd27
`define HLRB_SOFT_DSETTLE_DEF  5'd14
`define HLRB_LSC_DSETTLE_MIN   5'd4
`define HLRB_LSC_DSETTLE_MAX   5'd10
`define HLRB_LSC_DSETTLE_DEF   5'd6
`define HLRB_LSC_CSETTLE_MIN   5'd4
`define HLRB_LSC_CSETTLE_MAX   5'd19
`define HLRB_LSC_CSETTLE_DEF   5'd9
// Buffer shape
`define HLRB_DEPTH_DEF         128
`define HLRB_FIXED_DEPTH       4
`define HLRB_QUEUE_ENTRIES_DEF 4
`define HLRB_DELAY_DEF         8
`define HLRB_DELAY_MAX         16384
`define HLRB_CNT_WIDTH_DEF     4
// Lane entry pattern and header field positions
`define HLRB_SYNC_BYTE         8'hB8
`define HLRB_HDR_VC_MSB        7
`define HLRB_HDR_VC_LSB        6
`define HLRB_HDR_DT_MSB        5
`define HLRB_HDR_DT_LSB        0
`endif

// ==== hlrb_lane_tx.sv ====
`timescale 1ns/10ps
module hlrb_lane_tx (
  // Lane pins
  output logic       byte_clk,
  output logic       hs_req,
  output logic [7:0] lane_data
);
  localparam logic [7:0] SYNC = 8'hB8;

  initial begin
    byte_clk = 1'b0;
    hs_req = 1'b0;
    lane_data = 8'h00;
  end

  // One byte per link period; data moves on the falling edge
  task automatic tick(input logic [7:0] b);
    lane_data = b;
    #160 byte_clk = 1'b1;
    #160 byte_clk = 1'b0;
  endtask : tick

  // Clock only runs inside a burst; a decoy sync byte sits in the settle window
  task automatic send_burst(input logic [7:0] pl[$]);
    #7 hs_req = 1'b1;
    for (int i = 0; i < 18; i++) tick((i == 8) ? SYNC : 8'h55);
    tick(SYNC);
    foreach (pl[i]) tick(pl[i]);
    hs_req = 1'b0;
    // Released lane: four more ticks alternate ~last and the last payload byte, ending on the last payload byte
    for (int i = 0; i < 4; i++) tick(~lane_data);
  endtask : send_burst
endmodule : hlrb_lane_tx

// ==== hlrb_mem.sv ====
`timescale 1ns/10ps
// Simple dual-port storage with registered read data
module hlrb_mem #(
  parameter int AW   = 7,
  parameter int DW   = 9,
  parameter bit LUT  = 1'b0
) (
  // Clock
  input  wire logic          core_clk,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read side
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem_reg [0:(1<<AW)-1];
  logic [DW-1:0] rd_data_reg;

  // LUT flavour uses the same registered read as block RAM; same latency either way
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_reg <= mem_reg[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;

  initial begin
    if (AW < 2 || DW < 1 || (LUT !== 1'b0 && LUT !== 1'b1)) begin
      $error("hlrb_mem: bad shape");
    end
  end
endmodule : hlrb_mem

// ==== hlrb_pkg.sv ====
package hlrb_pkg;
  typedef enum logic [1:0] {
    HLRB_ORG_SINGLE    = 2'h0,
    HLRB_ORG_DUAL_BANK = 2'h1,
    HLRB_ORG_QUEUE     = 2'h2
  } hlrb_org_type;

  typedef enum logic [0:0] {
    HLRB_MEM_BLOCK_RAM = 1'h0,
    HLRB_MEM_LUT       = 1'h1
  } hlrb_mem_type;

  typedef enum logic [2:0] {
    HLRB_ST_IDLE   = 3'h0,
    HLRB_ST_CSETTL = 3'h1,
    HLRB_ST_DSETTL = 3'h2,
    HLRB_ST_SYNC   = 3'h3,
    HLRB_ST_HS     = 3'h4
  } hlrb_lane_state_type;

  typedef struct packed {
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic [15:0] wc;
    logic [7:0]  ecc;
    logic        valid;
  } hlrb_header_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } hlrb_word_type;
endpackage : hlrb_pkg

// ==== hlrb_rx.sv ====
`timescale 1ns/10ps
`include "hlrb_defines.svh"
// How it works
// RULE1 - Lane-state bypassed: wait data settle 1..27 (default 14) before capture.
// RULE2 - Lane-state used: data settle 4..10, default 6, custom-value option.
// RULE3 - Lane-state used: clock settle 4..19, default 9.
// RULE4 - Parser on: decode header and output its fields beside the data.
// RULE5 - Parser off: forward lane bytes unchanged, no header interpretation.
// RULE6 - Buffer disabled: pass data through a fixed four-register buffer.
// RULE7 - Hardened PHY: buffer always present, disable option refused.
// RULE8 - Buffer stores every burst fully, trailing bits included.
// RULE9 - Soft PHY: buffer also stores the zero bits before the payload.
// RULE10 - Depth is a power of two 16..4096, default 128.
// RULE11 - Storage block RAM or LUT memory, block RAM default.
// RULE12 - Queue organisation tracks 2, 4 or 8 entries, default 4.
// RULE13 - Organisation single, dual-bank or queue; dual-bank default.
// RULE14 - Debug option brings termination enables and status to ports.
// RULE15 - Lane alignment selectable only with the soft PHY.
// RULE16 - Single/dual-bank, delay zero: read only after whole burst written.
// RULE17 - Non-zero delay: read starts that many byte ticks after not-empty.
// RULE18 - Queue: counter of 1..14 bits counts write cycles per burst.
// RULE19 - Lane-state bypassed: soft logic controls clock and data lane states.
// RULE20 - Settle customisation off: the settle count takes its default.
// RULE21 - Settle counted in byte ticks from entry detection before data valid.
module hlrb_rx
  import hlrb_pkg::*;
#(
  parameter bit           HARD_PHY      = 1'b1,
  parameter bit           LSC_BYPASS    = 1'b1,
  parameter bit           CUST_DSETTLE  = 1'b0,
  parameter logic [4:0]   DSETTLE_VAL   = `HLRB_SOFT_DSETTLE_DEF,
  parameter bit           CUST_LSC_D    = 1'b0,
  parameter logic [4:0]   LSC_D_VAL     = `HLRB_LSC_DSETTLE_DEF,
  parameter bit           CUST_LSC_C    = 1'b0,
  parameter logic [4:0]   LSC_C_VAL     = `HLRB_LSC_CSETTLE_DEF,
  parameter bit           PARSER_EN     = 1'b1,
  parameter bit           DEBUG_EN      = 1'b0,
  parameter bit           LANE_ALIGN_EN = 1'b0,
  parameter bit           BUF_EN        = 1'b1,
  parameter hlrb_mem_type MEM_KIND      = HLRB_MEM_BLOCK_RAM,
  parameter int           DEPTH         = `HLRB_DEPTH_DEF,
  parameter hlrb_org_type ORG           = HLRB_ORG_DUAL_BANK,
  parameter int           Q_ENTRIES     = `HLRB_QUEUE_ENTRIES_DEF,
  parameter int           DELAY         = `HLRB_DELAY_DEF,
  parameter int           CNT_W         = `HLRB_CNT_WIDTH_DEF
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Link pins, from outside the clock domain
  input  wire logic       byte_rate_clock_in,
  input  wire logic       lane_hs_req,
  input  wire logic [7:0] lane_byte,
  // Fabric side
  input  wire logic       out_ready,
  output logic            out_valid,
  output hlrb_word_type   out_word,
  output hlrb_header_type out_header,
  // Debug status
  output logic            dbg_term_en,
  output logic            dbg_buf_empty,
  output logic            dbg_buf_full,
  output logic [CNT_W:0]  dbg_burst_len
);
  localparam int AW = $clog2(DEPTH);
  localparam int QW = $clog2(Q_ENTRIES);
  localparam logic [4:0] DSET = !LSC_BYPASS ? (CUST_LSC_D ? LSC_D_VAL :
      `HLRB_LSC_DSETTLE_DEF) : (CUST_DSETTLE ? DSETTLE_VAL : `HLRB_SOFT_DSETTLE_DEF); // RULE20
  localparam logic [4:0] CSET = CUST_LSC_C ? LSC_C_VAL : `HLRB_LSC_CSETTLE_DEF; // RULE20
  localparam bit USE_BUF = HARD_PHY ? 1'b1 : BUF_EN; // RULE7
  localparam int RAW_AW = USE_BUF ? AW : 2; // RULE6

  initial begin
    if (DEPTH < 16 || DEPTH > 4096 || (1 << AW) != DEPTH) $error("bad DEPTH"); // RULE10
    if (Q_ENTRIES != 2 && Q_ENTRIES != 4 && Q_ENTRIES != 8) $error("bad Q_ENTRIES"); // RULE12
    if (CNT_W < 1 || CNT_W > 14) $error("bad CNT_W"); // RULE18
    if (DELAY < 0 || DELAY > `HLRB_DELAY_MAX) $error("bad DELAY"); // RULE17
    if (LSC_BYPASS && (DSETTLE_VAL < `HLRB_SOFT_DSETTLE_MIN ||
        DSETTLE_VAL > `HLRB_SOFT_DSETTLE_MAX)) $error("bad DSETTLE_VAL"); // RULE1
    if (!LSC_BYPASS && (LSC_D_VAL < `HLRB_LSC_DSETTLE_MIN ||
        LSC_D_VAL > `HLRB_LSC_DSETTLE_MAX)) $error("bad LSC_D_VAL"); // RULE2
    if (!LSC_BYPASS && (LSC_C_VAL < `HLRB_LSC_CSETTLE_MIN ||
        LSC_C_VAL > `HLRB_LSC_CSETTLE_MAX)) $error("bad LSC_C_VAL"); // RULE3
    if (HARD_PHY && !BUF_EN) $error("buffer cannot be disabled on hard PHY"); // RULE7
    if (HARD_PHY && LANE_ALIGN_EN) $error("lane align needs soft PHY"); // RULE15
  end

  // Two-flop synchronisers on every link pin
  logic [2:0]  clk_sy_reg, clk_sy_next;
  logic [1:0]  req_sy_reg, req_sy_next;
  logic [15:0] dat_sy_reg, dat_sy_next;
  logic        tick;
  always_comb begin
    clk_sy_next = {clk_sy_reg[1:0], byte_rate_clock_in};
    req_sy_next = {req_sy_reg[0], lane_hs_req};
    dat_sy_next = {dat_sy_reg[7:0], lane_byte};
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_sy_reg <= 3'h0;
      req_sy_reg <= 2'h0;
      dat_sy_reg <= 16'h0000;
    end else begin
      clk_sy_reg <= clk_sy_next;
      req_sy_reg <= req_sy_next;
      dat_sy_reg <= dat_sy_next;
    end
  end
  // Rising edge seen between second and third stage; first stage stays private
  assign tick = clk_sy_reg[1] & ~clk_sy_reg[2];

  // Lane state sequencer: soft takeover when the hardened logic is bypassed
  hlrb_lane_state_type st_reg, st_next;
  logic [4:0]          cnt_reg, cnt_next;
  logic                term_reg, term_next;
  logic                cap_reg, cap_next;
  logic                last_reg, last_next;
  logic                hdr_cnt_en;
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    term_next = term_reg;
    cap_next  = 1'b0;
    last_next = 1'b0;
    if (tick) begin
      case (st_reg)
        HLRB_ST_IDLE: begin
          cnt_next = 5'h00;
          if (req_sy_reg[1]) begin // RULE21
            term_next = 1'b1;
            st_next   = LSC_BYPASS ? HLRB_ST_DSETTL : HLRB_ST_CSETTL; // RULE19
          end
        end
        HLRB_ST_CSETTL: begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg + 5'h01 >= CSET) begin // RULE3
            cnt_next = 5'h00;
            st_next  = HLRB_ST_DSETTL;
          end
        end
        HLRB_ST_DSETTL: begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg + 5'h01 >= DSET) begin // RULE1 RULE2 RULE21
            st_next = HLRB_ST_SYNC;
          end
        end
        HLRB_ST_SYNC: begin
          // Soft PHY keeps the zero bytes ahead of the sync byte
          cap_next = !HARD_PHY; // RULE9
          // Hard PHY: sync byte not stored, so the parser sees payload byte 0 first; soft PHY stores it and parses it as byte 0
          if (dat_sy_reg[15:8] == `HLRB_SYNC_BYTE) begin
            st_next  = HLRB_ST_HS;
          end
          if (!req_sy_reg[1]) begin
            st_next   = HLRB_ST_IDLE;
            term_next = 1'b0;
            last_next = cap_next;
          end
        end
        HLRB_ST_HS: begin
          cap_next = 1'b1; // RULE8
          if (!req_sy_reg[1]) begin
            last_next = 1'b1;
            term_next = 1'b0;
            st_next   = HLRB_ST_IDLE;
          end
        end
        default: st_next = HLRB_ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg   <= HLRB_ST_IDLE;
      cnt_reg  <= 5'h00;
      term_reg <= 1'b0;
      cap_reg  <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      term_reg <= term_next;
      cap_reg  <= cap_next;
      last_reg <= last_next;
    end
  end
  assign hdr_cnt_en = cap_reg && st_reg == HLRB_ST_HS;

  // Buffer: circular store, read gating by organisation
  logic [RAW_AW:0]  wp_reg, wp_next, rp_reg, rp_next;
  logic [14:0]      dly_reg, dly_next;
  logic [CNT_W:0]   blen_reg, blen_next;
  logic [QW:0]      qcnt_reg, qcnt_next;
  logic             done_reg, done_next;
  logic             empty, full, rd_ok, rd_fire;
  logic             ov_reg, ov_next;
  logic [8:0]       rd_data;
  always_comb begin
    empty   = wp_reg == rp_reg;
    full    = (wp_reg[RAW_AW] != rp_reg[RAW_AW]) &&
              (wp_reg[RAW_AW-1:0] == rp_reg[RAW_AW-1:0]);
    wp_next = wp_reg + {{RAW_AW{1'b0}}, cap_reg & ~full};
    dly_next  = dly_reg;
    done_next = done_reg;
    blen_next = blen_reg;
    qcnt_next = qcnt_reg;
    if (cap_reg & ~full) begin
      blen_next = (blen_reg == {1'b0, {CNT_W{1'b1}}}) ? blen_reg : blen_reg + 1'b1; // RULE18
    end
    if (last_reg) begin
      done_next = 1'b1; // RULE16
      blen_next = '0;
    end
    if (!empty && dly_reg != DELAY[14:0] && tick) begin
      dly_next = dly_reg + 15'h0001; // RULE17
    end
    if (!USE_BUF) begin
      rd_ok = !empty; // RULE6
    end else if (ORG == HLRB_ORG_QUEUE) begin
      rd_ok = !empty && (qcnt_reg != '0); // RULE12
    end else if (DELAY == 0) begin
      rd_ok = !empty && done_reg; // RULE16
    end else begin
      rd_ok = !empty && dly_reg == DELAY[14:0]; // RULE17
    end
    rd_fire = rd_ok && (!ov_reg || out_ready);
    rp_next = rp_reg + {{RAW_AW{1'b0}}, rd_fire};
    ov_next = rd_fire ? 1'b1 : (out_ready ? 1'b0 : ov_reg);
    // Queue credit: one per finished burst, spent when its last word is taken while the next word is read
    if (last_reg && qcnt_reg != Q_ENTRIES[QW:0]) begin
      qcnt_next = qcnt_reg + 1'b1;
    end
    if (rd_fire && empty_after_last(rd_data, ov_reg, out_ready) && qcnt_next != '0) begin
      qcnt_next = qcnt_next - 1'b1;
    end
    if (empty) begin
      dly_next  = 15'h0000;
      if (!last_reg) done_next = 1'b0;
    end
  end

  function automatic logic empty_after_last(input logic [8:0] w, input logic ov,
                                            input logic rdy);
    empty_after_last = ov & rdy & w[0];
  endfunction : empty_after_last

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp_reg   <= '0;
      rp_reg   <= '0;
      dly_reg  <= 15'h0000;
      done_reg <= 1'b0;
      blen_reg <= '0;
      qcnt_reg <= '0;
      ov_reg   <= 1'b0;
    end else begin
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      dly_reg  <= dly_next;
      done_reg <= done_next;
      blen_reg <= blen_next;
      qcnt_reg <= qcnt_next;
      ov_reg   <= ov_next;
    end
  end

  hlrb_mem #(
    .AW  (RAW_AW),
    .DW  (9),
    .LUT (MEM_KIND == HLRB_MEM_LUT) // RULE11
  ) u_mem (
    .core_clk (core_clk),
    .wr_en    (cap_reg & ~full), // RULE8
    .wr_addr  (wp_reg[RAW_AW-1:0]),
    .wr_data  ({dat_sy_reg[15:8], last_next_word(last_reg, st_reg)}), // RULE8
    .rd_en    (rd_fire),
    .rd_addr  (rp_reg[RAW_AW-1:0]),
    .rd_data  (rd_data)
  );

  function automatic logic last_next_word(input logic ln, input hlrb_lane_state_type s);
    last_next_word = ln & (s == HLRB_ST_IDLE);
  endfunction : last_next_word

  // Header parser on the captured stream: first four bytes after sync on hard PHY; soft PHY starts at the sync byte
  hlrb_header_type hdr_reg, hdr_next;
  logic [2:0]      hidx_reg, hidx_next;
  always_comb begin
    hdr_next  = hdr_reg;
    hidx_next = hidx_reg;
    if (PARSER_EN && hdr_cnt_en && !full) begin // RULE4
      case (hidx_reg)
        3'h0: begin
          hdr_next.vc    = dat_sy_reg[`HLRB_HDR_VC_MSB+8:`HLRB_HDR_VC_LSB+8];
          hdr_next.dt    = dat_sy_reg[`HLRB_HDR_DT_MSB+8:`HLRB_HDR_DT_LSB+8];
          hdr_next.valid = 1'b0;
        end
        3'h1: hdr_next.wc[7:0]  = dat_sy_reg[15:8];
        3'h2: hdr_next.wc[15:8] = dat_sy_reg[15:8];
        3'h3: begin
          hdr_next.ecc   = dat_sy_reg[15:8];
          hdr_next.valid = 1'b1;
        end
        default: hdr_next = hdr_reg;
      endcase
      if (hidx_reg != 3'h4) hidx_next = hidx_reg + 3'h1;
    end
    if (last_reg) hidx_next = 3'h0;
    if (!PARSER_EN) hdr_next = '0; // RULE5
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hdr_reg  <= '0;
      hidx_reg <= 3'h0;
    end else begin
      hdr_reg  <= hdr_next;
      hidx_reg <= hidx_next;
    end
  end

  // Output registers; data byte is passed as stored, untouched
  logic            oval_reg, oval_next;
  hlrb_word_type   ow_reg, ow_next;
  logic            dte_reg, dbe_reg, dbf_reg;
  logic [CNT_W:0]  dbl_reg;
  always_comb begin
    oval_next = ov_reg & ~(oval_reg & out_ready) | (ov_next & rd_fire);
    oval_next = ov_next;
    ow_next   = out_word;
    if (ov_reg && !(oval_reg && !out_ready)) ow_next = '{data: rd_data[8:1], last: rd_data[0]}; // RULE5
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oval_reg <= 1'b0;
      ow_reg   <= '0;
      dte_reg  <= 1'b0;
      dbe_reg  <= 1'b1;
      dbf_reg  <= 1'b0;
      dbl_reg  <= '0;
    end else begin
      oval_reg <= oval_next;
      ow_reg   <= ow_next;
      dte_reg  <= DEBUG_EN & term_reg; // RULE14
      dbe_reg  <= DEBUG_EN ? empty : 1'b1; // RULE14
      dbf_reg  <= DEBUG_EN & full; // RULE14
      dbl_reg  <= DEBUG_EN ? blen_reg : '0; // RULE14
    end
  end

  assign out_valid     = ov_reg;
  assign out_word      = '{data: rd_data[8:1], last: rd_data[0]};
  assign out_header    = hdr_reg;
  assign dbg_term_en   = dte_reg;
  assign dbg_buf_empty = dbe_reg;
  assign dbg_buf_full  = dbf_reg;
  assign dbg_burst_len = dbl_reg;
endmodule : hlrb_rx

// ==== hlrb_rx_assertions.sv ====
`timescale 1ns/10ps
module hlrb_rx_chk
  import hlrb_pkg::*;
#(
  parameter bit PARSER_EN = 1'b1,
  parameter bit DEBUG_EN  = 1'b0,
  parameter int DELAY     = 8,
  parameter int CNT_W     = 4
) (
  // Clock and reset
  input wire logic            core_clk,
  input wire logic            nrst,
  // Lane and fabric
  input wire logic            lane_hs_req,
  input wire logic            out_ready,
  input wire logic            out_valid,
  input wire hlrb_word_type   out_word,
  input wire hlrb_header_type out_header,
  // Debug status
  input wire logic            dbg_term_en,
  input wire logic            dbg_buf_empty,
  input wire logic            dbg_buf_full,
  input wire logic [CNT_W:0]  dbg_burst_len
);
  logic hold_reg;
  logic hold_next;
  logic seen_reg;
  logic seen_next;

  // Burst started on an empty, idle buffer: nothing may leave until the lane drops
  always_comb begin
    hold_next = hold_reg;
    if (!lane_hs_req) begin
      hold_next = 1'b0;
    end else if (dbg_buf_empty && !out_valid) begin
      hold_next = 1'b1;
    end
    seen_next = seen_reg | lane_hs_req;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      seen_reg <= seen_next;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_valid_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("word changed before it was taken");
  a_raw_header_zero: assert property (!PARSER_EN |-> out_header == '0)
    else $error("header decoded with parser off");
  a_read_held: assert property (hold_reg && DEBUG_EN && DELAY == 0 |-> !out_valid)
    else $error("read opened before burst end");
  a_empty_quiet: assert property (DEBUG_EN && dbg_buf_empty && !out_valid |=> !out_valid)
    else $error("word out of an empty buffer");
  a_reset_quiet: assert property ($rose(nrst) |-> !out_valid && dbg_buf_empty && !dbg_buf_full)
    else $error("outputs not idle after reset");
  a_empty_full: assert property (DEBUG_EN |-> !(dbg_buf_empty && dbg_buf_full))
    else $error("buffer both empty and full");
  a_debug_off: assert property (!DEBUG_EN |-> dbg_buf_empty && !dbg_buf_full
    && !dbg_term_en && dbg_burst_len == '0)
    else $error("debug ports active while disabled");
  a_no_phantom: assert property (!seen_reg |-> !out_valid)
    else $error("word without any burst");
endmodule : hlrb_rx_chk

bind hlrb_rx hlrb_rx_chk #(
  .PARSER_EN(PARSER_EN), .DEBUG_EN(DEBUG_EN), .DELAY(DELAY), .CNT_W(CNT_W)
) u_chk (
  .core_clk(core_clk), .nrst(nrst), .lane_hs_req(lane_hs_req), .out_ready(out_ready),
  .out_valid(out_valid), .out_word(out_word), .out_header(out_header),
  .dbg_term_en(dbg_term_en), .dbg_buf_empty(dbg_buf_empty), .dbg_buf_full(dbg_buf_full),
  .dbg_burst_len(dbg_burst_len)
);

// ==== hlrb_rx_tb_top.sv ====
`timescale 1ns/10ps
module hlrb_rx_tb_top
  import hlrb_pkg::*;
;
  logic            core_clk;
  logic            nrst;
  logic            bclk;
  logic            req;
  logic [7:0]      lbyte;
  logic            rdy [2];
  logic            vld [2];
  hlrb_word_type   word [2];
  hlrb_header_type hdr [2];
  logic            d_empty;
  logic            d_full;
  logic            d_term;
  logic [4:0]      d_blen;
  logic            r_empty;
  int              fail_count;
  int              samples_checked;

  hlrb_lane_tx tx (.byte_clk(bclk), .hs_req(req), .lane_data(lbyte));

  // Small single buffer, whole-burst read gate
  hlrb_rx #(.DEPTH(16), .ORG(HLRB_ORG_SINGLE), .DELAY(0), .DEBUG_EN(1'b1)) dut (
    .core_clk(core_clk), .nrst(nrst), .byte_rate_clock_in(bclk), .lane_hs_req(req),
    .lane_byte(lbyte), .out_ready(rdy[0]), .out_valid(vld[0]), .out_word(word[0]),
    .out_header(hdr[0]), .dbg_term_en(d_term), .dbg_buf_empty(d_empty), .dbg_buf_full(d_full),
    .dbg_burst_len(d_blen));

  // Raw bytes through a two-entry queue in lookup-table memory
  hlrb_rx #(.PARSER_EN(1'b0), .MEM_KIND(HLRB_MEM_LUT), .DEPTH(32),
    .ORG(HLRB_ORG_QUEUE), .Q_ENTRIES(2), .DELAY(0)) dut_raw (
    .core_clk(core_clk), .nrst(nrst), .byte_rate_clock_in(bclk), .lane_hs_req(req),
    .lane_byte(lbyte), .out_ready(rdy[1]), .out_valid(vld[1]), .out_word(word[1]),
    .out_header(hdr[1]), .dbg_term_en(), .dbg_buf_empty(r_empty), .dbg_buf_full(),
    .dbg_burst_len());

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Word is sampled while it stands, then taken by one ready edge
  task automatic read_word(input int s, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (vld[s] !== 1'b1 && n < 2000);
    check("out_valid", vld[s], 1'b1);
    check("out_word.data", word[s].data, d);
    check("out_word.last", word[s].last, l);
    rdy[s] <= 1'b1;
    @(negedge core_clk);
    rdy[s] <= 1'b0;
  endtask : read_word

  task automatic read_burst(input int s, input logic [7:0] q[$]);
    // Payload words, then the trailing byte that ends the burst carries the last flag
    foreach (q[i]) read_word(s, q[i], 1'b0);
    read_word(s, ~q[q.size() - 1], 1'b1);
  endtask : read_burst

  initial begin
    logic [7:0] pa[$];
    logic [7:0] pb[$];
    logic [7:0] pc[$];
    fail_count = 0;
    samples_checked = 0;
    nrst = 1'b0;
    rdy[0] = 1'b0;
    rdy[1] = 1'b0;
    // Payload data repeats the sync byte on purpose
    pa = '{8'hAB, 8'h03, 8'h00, 8'h1C, 8'hB8, 8'h00, 8'hFF};
    pb = '{8'h12, 8'h01, 8'h00, 8'h07, 8'h5A};
    pc = '{8'hFF, 8'h02, 8'h01, 8'h3E, 8'h80};
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    check("dbg_buf_empty", d_empty, 1'b1);
    fork
      tx.send_burst(pa);
      begin
        #3000;
        check("dbg_term_en", d_term, 1'b1);
        #4480;
        check("dbg_burst_len", d_blen, 5'h04);
      end
    join
    @(negedge core_clk);
    check("dbg_term_en", d_term, 1'b0);
    check("dbg_burst_len", d_blen, 5'h00);
    check("dbg_buf_empty raw", r_empty, 1'b1);
    check("dbg_buf_empty", d_empty, 1'b0);
    check("dbg_buf_full", d_full, 1'b0);
    check("out_header", hdr[0], {2'h2, 6'h2B, 16'h0003, 8'h1C, 1'b1});
    check("out_header raw", hdr[1], 40'h0);
    read_burst(0, pa);
    read_burst(1, pa);
    repeat (4) @(negedge core_clk);
    check("dbg_buf_empty", d_empty, 1'b1);
    // Back-to-back bursts, both left unread until the lane is idle
    tx.send_burst(pb);
    tx.send_burst(pc);
    @(negedge core_clk);
    check("out_header", hdr[0], {2'h3, 6'h3F, 16'h0102, 8'h3E, 1'b1});
    read_burst(0, pb);
    read_burst(0, pc);
    read_burst(1, pb);
    read_burst(1, pc);
    give_verdict();
  end

  // Whole run needs well under a tenth of this
  initial begin
    #500000;
    fail_count++;
    give_verdict();
  end
endmodule : hlrb_rx_tb_top
